//--- logic/rtp_pkg.sv
// shared constants and carrier types for the reload timer block
`default_nettype none
package rtp_pkg;

    // ****
    // widths and reset values
    // ****
    localparam int CNT_W = 12;
    localparam int NUM_CH = 4;
    localparam logic [11:0] CNT_RESET = 12'h000;
    localparam logic [11:0] CNT_MAX = 12'hFFF;
    localparam logic [11:0] RELOAD_RESET = 12'h000;
    localparam logic [11:0] DUTY_RESET = 12'h000;
    localparam logic [3:0] OE_RESET = 4'h0;
    localparam logic [3:0] PIN_RESET = 4'h0;

    // ****
    // counter clock choice, in field order 00..11
    // ****
    typedef enum logic [1:0] {
        RTP_CLK_OFF,
        RTP_CLK_LITE,
        RTP_CLK_CPU,
        RTP_CLK_FAST
    } rtp_clk_sel_e;

    // ****
    // software write strobes with their shared data word
    // ****
    typedef struct packed {
        logic [11:0] data;
        logic        reload_wr;
        logic [3:0]  duty_wr;
        logic        oe_wr;
    } rtp_sw_wr_s;

    // ****
    // emergency stop controls
    // ****
    typedef struct packed {
        logic [3:0] pattern;
        logic       pin_enable;
        logic       set_stop;
        logic       clear_stop;
    } rtp_stop_ctl_s;

endpackage
`default_nettype wire

//--- logic/rtp_sync.sv
// two flip-flop synchroniser for asynchronous pin inputs
`default_nettype none
`timescale 1ns/1ns
module rtp_sync #(
    parameter int W = 2
) (
    input  wire logic         sys_clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);

    // first stage is read only by the second
    logic [W-1:0] meta;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta     <= '1;
            sync_out <= '1;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule // rtp_sync
`default_nettype wire

//--- logic/rtp_channel.sv
// one modulated channel: duty shadow, compare, flag, polarity
`default_nettype none
`timescale 1ns/1ns
module rtp_channel #(
    parameter int W = rtp_pkg::CNT_W
) (
    input  wire logic         sys_clk_in,
    input  wire logic         rst_n_in,
    input  wire logic         step_in,
    input  wire logic         wrap_in,
    input  wire logic [W-1:0] count_in,
    input  wire logic         stop_clr_in,
    input  wire logic         duty_wr_in,
    input  wire logic [W-1:0] duty_data_in,
    input  wire logic         pol_in,
    input  wire logic         pol_sync_in,
    input  wire logic         flag_rd_in,
    output var  logic         level_out,
    output var  logic         pol_out,
    output var  logic         flag_out,
    output var  logic [W-1:0] duty_out
);

    logic [W-1:0] shadow;
    logic [W-1:0] cmp_val;
    logic         match;

    // at a wrap the new duty is already the one compared
    assign cmp_val = wrap_in ? shadow : duty_out;
    assign match   = step_in && (count_in == cmp_val);

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            shadow <= rtp_pkg::DUTY_RESET;
        end else if (stop_clr_in) begin
            shadow <= rtp_pkg::DUTY_RESET;
        end else if (duty_wr_in) begin
            shadow <= duty_data_in;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            duty_out <= rtp_pkg::DUTY_RESET;
        end else if (stop_clr_in) begin
            duty_out <= rtp_pkg::DUTY_RESET;
        end else if (wrap_in) begin
            duty_out <= shadow;
        end
    end

    // match beats wrap: duty not above reload yields no pulse
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            level_out <= 1'b0;
        end else if (stop_clr_in) begin
            level_out <= 1'b0;
        end else if (match) begin
            level_out <= 1'b0;
        end else if (wrap_in) begin
            level_out <= (count_in < cmp_val);
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pol_out <= 1'b0;
        end else if (!pol_sync_in || wrap_in) begin
            pol_out <= pol_in;
        end
    end

    // set wins over the read that clears
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flag_out <= 1'b0;
        end else if (match && (cmp_val != rtp_pkg::DUTY_RESET)) begin
            flag_out <= 1'b1;
        end else if (flag_rd_in) begin
            flag_out <= 1'b0;
        end
    end

endmodule // rtp_channel
`default_nettype wire

//--- logic/rtp_timer_top.sv
// reload timer with four modulated channels, stop and capture
//
// Notes on behaviour
// - one 12-bit free-running up-counter serves all channels and capture.
// - after reset the counter starts counting from zero.
// - period is 4096 minus reload value counts, shared by all channels.
// - at each wrap, preloaded duties become active and outputs with duty above reload go high.
// - counter equal to active duty drives that channel low until wrap.
// - each channel output has its own enable bit.
// - polarity inverts output; with sync select, change lands at wrap.
// - counter reaching duty sets compare flag and requests interrupt.
// - no compare flag or interrupt when duty holds zero.
// - stop pin is active low and obeyed only when enabled.
// - low level on enabled stop pin sets stop active.
// - software may set stop active without the pin.
// - while stopped, pattern bits drive pins directly, without inversion.
// - stop entry resets counter and clears output enables.
// - stop entry resets reload, duties and their shadows.
// - software clearing stop returns pins to general port values.
// - either capture pin edge latches counter and sets capture flag.
// - capture raises interrupt request when capture interrupt enabled.
// - reading capture value while flag set clears it; value read-only.
// - further edges ignored while capture flag set, except in the cycle of a clearing read.
// - wrap from maximum reloads the counter from reload value.
// - clock select picks off, lite tick, cpu clock or fast tick.
// - reading a channel status clears its compare flag.
`default_nettype none
`timescale 1ns/1ns
module rtp_timer_top #(
    parameter int W  = rtp_pkg::CNT_W,
    parameter int NC = rtp_pkg::NUM_CH
) (
    input  wire logic                  sys_clk_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  lite_tick_in,
    input  wire logic                  fast_tick_in,
    input  wire rtp_pkg::rtp_clk_sel_e count_clock_sel_in,
    input  wire rtp_pkg::rtp_sw_wr_s   sw_wr_in,
    input  wire rtp_pkg::rtp_stop_ctl_s stop_ctl_in,
    input  wire logic [NC-1:0]         polarity_in,
    input  wire logic                  polarity_sync_sel_in,
    input  wire logic                  compare_irq_en_in,
    input  wire logic                  capture_irq_en_in,
    input  wire logic                  wrap_irq_en_in,
    input  wire logic [NC-1:0]         status_rd_in,
    input  wire logic                  capture_rd_in,
    input  wire logic                  wrap_rd_in,
    input  wire logic [NC-1:0]         port_value_in,
    input  wire logic                  emergency_stop_pin_n_in,
    input  wire logic                  capture_input_pin_in,
    output var  logic [NC-1:0]         modulated_out,
    output var  logic [NC-1:0]         modulated_oe_out,
    output var  logic [W-1:0]          count_value_out,
    output var  logic [W-1:0]          reload_value_out,
    output var  logic [NC-1:0]         output_enable_out,
    output var  logic [W-1:0]          capture_value_out,
    output var  logic                  capture_flag_out,
    output var  logic [NC-1:0]         compare_flag_out,
    output var  logic                  wrap_flag_out,
    output var  logic                  stop_active_out,
    output var  logic                  compare_irq_out,
    output var  logic                  capture_irq_out,
    output var  logic                  wrap_irq_out
);

    // ****
    // internal signals
    // ****
    // pins, capture
    logic [1:0]    pins_sync;
    logic          stop_pin_low;
    logic          cap_level;
    logic          cap_prev;
    logic          cap_edge;
    logic          cap_take;

    // count steps
    logic          tick;
    logic          step;
    logic          wrap;

    // stop
    logic          stop_hold;
    logic          stop_entry;
    logic          next_stop_active;

    // channels
    logic [NC-1:0] ch_level;
    logic [NC-1:0] ch_pol;
    logic [W-1:0]  ch_duty [NC];

    // pin drive
    logic [NC-1:0] next_pins;
    logic [NC-1:0] next_pins_oe;

    // ****
    // pin synchronisers
    // ****
    // both idle high
    rtp_sync #(
        .W (2)
    ) u_pin_sync (
        .sys_clk_in (sys_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   ({capture_input_pin_in, emergency_stop_pin_n_in}),
        .sync_out   (pins_sync)
    );

    assign stop_pin_low = stop_ctl_in.pin_enable && !pins_sync[0];
    assign cap_level    = pins_sync[1];

    // ****
    // counter clock selection
    // ****
    // one tick, one step
    // lite and fast ticks are one-cycle enables from local logic
    always_comb begin
        case (count_clock_sel_in)
            rtp_pkg::RTP_CLK_OFF:  tick = 1'b0;
            rtp_pkg::RTP_CLK_LITE: tick = lite_tick_in;
            rtp_pkg::RTP_CLK_CPU:  tick = 1'b1;
            rtp_pkg::RTP_CLK_FAST: tick = fast_tick_in;
            default:               tick = 1'b0;
        endcase
    end

    // ****
    // emergency stop
    // ****
    // pin lags two edges
    // software needs no pin
    // a set from pin or software wins over a software clear
    always_comb begin
        next_stop_active = stop_active_out;
        if (stop_pin_low || stop_ctl_in.set_stop) begin
            next_stop_active = 1'b1;
        end else if (stop_ctl_in.clear_stop) begin
            next_stop_active = 1'b0;
        end
    end

    assign stop_entry = next_stop_active && !stop_active_out;
    // held while stopped so nothing restarts until released
    assign stop_hold  = stop_entry || stop_active_out;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stop_active_out <= 1'b0;
        end else begin
            stop_active_out <= next_stop_active;
        end
    end

    // ****
    // up-counter with auto reload
    // ****
    // zero while stopped
    // reload used at wrap
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_value_out <= rtp_pkg::CNT_RESET;
        end else if (stop_hold) begin
            count_value_out <= rtp_pkg::CNT_RESET;
        end else if (tick) begin
            if (count_value_out == rtp_pkg::CNT_MAX) begin
                count_value_out <= reload_value_out;
            end else begin
                count_value_out <= count_value_out + 1'b1;
            end
        end
    end

    // step and wrap mark the cycle in which the new count shows
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            step <= 1'b0;
            wrap <= 1'b0;
        end else begin
            step <= tick && !stop_hold;
            wrap <= tick && !stop_hold
                    && (count_value_out == rtp_pkg::CNT_MAX);
        end
    end

    // ****
    // software registers cleared by stop entry
    // ****
    // entry beats writes
    // writes land next edge
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reload_value_out <= rtp_pkg::RELOAD_RESET;
        end else if (stop_entry) begin
            reload_value_out <= rtp_pkg::RELOAD_RESET;
        end else if (sw_wr_in.reload_wr) begin
            reload_value_out <= sw_wr_in.data;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            output_enable_out <= rtp_pkg::OE_RESET;
        end else if (stop_entry) begin
            output_enable_out <= rtp_pkg::OE_RESET;
        end else if (sw_wr_in.oe_wr) begin
            output_enable_out <= sw_wr_in.data[NC-1:0];
        end
    end

    // ****
    // modulated channels
    // ****
    // one shared count
    // duties load at wrap
    for (genvar i = 0; i < NC; i++) begin : g_ch
        rtp_channel #(
            .W (W)
        ) u_ch (
            .sys_clk_in   (sys_clk_in),
            .rst_n_in     (rst_n_in),
            .step_in      (step),
            .wrap_in      (wrap),
            .count_in     (count_value_out),
            .stop_clr_in  (stop_entry),
            .duty_wr_in   (sw_wr_in.duty_wr[i]),
            .duty_data_in (sw_wr_in.data),
            .pol_in       (polarity_in[i]),
            .pol_sync_in  (polarity_sync_sel_in),
            .flag_rd_in   (status_rd_in[i]),
            .level_out    (ch_level[i]),
            .pol_out      (ch_pol[i]),
            .flag_out     (compare_flag_out[i]),
            .duty_out     (ch_duty[i])
        );
    end

    // ****
    // pin drive selection
    // ****
    // stop, enable, port
    // no glitch on pins
    // the stop pattern bypasses the inverter on purpose
    always_comb begin
        next_pins    = rtp_pkg::PIN_RESET;
        next_pins_oe = rtp_pkg::PIN_RESET;
        for (int i = 0; i < NC; i++) begin
            if (next_stop_active) begin
                next_pins[i]    = stop_ctl_in.pattern[i];
                next_pins_oe[i] = 1'b1;
            end else if (output_enable_out[i]) begin
                next_pins[i]    = ch_level[i] ^ ch_pol[i];
                next_pins_oe[i] = 1'b1;
            end else begin
                next_pins[i]    = port_value_in[i];
                next_pins_oe[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            modulated_out    <= rtp_pkg::PIN_RESET;
            modulated_oe_out <= rtp_pkg::PIN_RESET;
        end else begin
            modulated_out    <= next_pins;
            modulated_oe_out <= next_pins_oe;
        end
    end

    // ****
    // input capture
    // ****
    // prev resets high
    // edge is any change
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cap_prev <= 1'b1;
        end else begin
            cap_prev <= cap_level;
        end
    end

    assign cap_edge = cap_level ^ cap_prev;
    // an edge in the clearing read cycle is still taken
    assign cap_take = cap_edge && (!capture_flag_out || capture_rd_in);

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            capture_value_out <= rtp_pkg::CNT_RESET;
        end else if (cap_take) begin
            capture_value_out <= count_value_out;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            capture_flag_out <= 1'b0;
        end else if (cap_take) begin
            capture_flag_out <= 1'b1;
        end else if (capture_rd_in) begin
            capture_flag_out <= 1'b0;
        end
    end

    // ****
    // wrap flag
    // ****
    // set beats read
    // marks reload shown
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wrap_flag_out <= 1'b0;
        end else if (wrap) begin
            wrap_flag_out <= 1'b1;
        end else if (wrap_rd_in) begin
            wrap_flag_out <= 1'b0;
        end
    end

    // ****
    // interrupt requests
    // ****
    // levels, not pulses
    // levels follow the flags one cycle later
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            compare_irq_out <= 1'b0;
            capture_irq_out <= 1'b0;
            wrap_irq_out    <= 1'b0;
        end else begin
            compare_irq_out <= compare_irq_en_in
                               && (|compare_flag_out);
            capture_irq_out <= capture_irq_en_in
                               && capture_flag_out;
            wrap_irq_out    <= wrap_irq_en_in && wrap_flag_out;
        end
    end

endmodule // rtp_timer_top
`default_nettype wire

//--- sim/rtp_timer_monitor.sv
// assertions on the reload timer top ports, attached by bind
`timescale 1ns/1ns
`default_nettype none
module rtp_timer_monitor #(
    parameter int W  = rtp_pkg::CNT_W,
    parameter int NC = rtp_pkg::NUM_CH
) (
    input wire logic                   sys_clk_in,
    input wire logic                   rst_n_in,
    input wire logic                   lite_tick_in,
    input wire logic                   fast_tick_in,
    input wire rtp_pkg::rtp_clk_sel_e  count_clock_sel_in,
    input wire rtp_pkg::rtp_stop_ctl_s stop_ctl_in,
    input wire logic                   emergency_stop_pin_n_in,
    input wire logic                   capture_rd_in,
    input wire logic                   capture_irq_en_in,
    input wire logic                   compare_irq_en_in,
    input wire logic [NC-1:0]          modulated_out,
    input wire logic [NC-1:0]          modulated_oe_out,
    input wire logic [NC-1:0]          output_enable_out,
    input wire logic [NC-1:0]          compare_flag_out,
    input wire logic [W-1:0]           count_value_out,
    input wire logic [W-1:0]           reload_value_out,
    input wire logic [W-1:0]           capture_value_out,
    input wire logic                   capture_flag_out,
    input wire logic                   stop_active_out,
    input wire logic                   compare_irq_out,
    input wire logic                   capture_irq_out
);
    logic step_now;
    logic free_run;
    assign step_now = count_clock_sel_in == rtp_pkg::RTP_CLK_CPU
        || (count_clock_sel_in == rtp_pkg::RTP_CLK_LITE && lite_tick_in)
        || (count_clock_sel_in == rtp_pkg::RTP_CLK_FAST && fast_tick_in);
    // pin enable excluded: a synced low may still be in flight
    assign free_run = !stop_active_out && !stop_ctl_in.set_stop
        && !stop_ctl_in.pin_enable;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence pin_low_s;
        (stop_ctl_in.pin_enable && !emergency_stop_pin_n_in) [*3];
    endsequence
    count_step_a: assert property (step_now && free_run
        && count_value_out != 12'hFFF |=> count_value_out
        == $past(count_value_out) + 12'h001) else $error("count step");
    wrap_reload_a: assert property (step_now && free_run
        && count_value_out == 12'hFFF |=> count_value_out
        == $past(reload_value_out)) else $error("wrap reload");
    count_hold_a: assert property (!step_now && free_run
        |=> $stable(count_value_out)) else $error("count moved");
    stop_entry_a: assert property ($rose(stop_active_out)
        |-> count_value_out == 12'h000 && reload_value_out == 12'h000
        && output_enable_out == 4'h0) else $error("stop entry");
    stop_pattern_a: assert property (stop_active_out |->
        modulated_out == $past(stop_ctl_in.pattern)
        && modulated_oe_out == 4'hF) else $error("stop pattern");
    soft_stop_a: assert property (stop_ctl_in.set_stop
        |=> stop_active_out) else $error("soft stop");
    pin_stop_a: assert property (pin_low_s |=> stop_active_out)
        else $error("pin stop");
    pin_ignored_a: assert property (!stop_active_out
        && !stop_ctl_in.set_stop && !stop_ctl_in.pin_enable
        |=> !stop_active_out) else $error("pin ignored");
    capture_hold_a: assert property (capture_flag_out
        && !capture_rd_in |=> capture_flag_out
        && $stable(capture_value_out)) else $error("capture hold");
    capture_irq_a: assert property (capture_irq_out ==
        $past(capture_irq_en_in && capture_flag_out)) else $error("cap irq");
    compare_irq_a: assert property (compare_irq_out ==
        $past(compare_irq_en_in && (|compare_flag_out)))
        else $error("cmp irq");
endmodule // rtp_timer_monitor
bind rtp_timer_top rtp_timer_monitor #(.W(W), .NC(NC)) mon (.*);
`default_nettype wire

//--- sim/rtp_far_side.sv
// model of the converter stage and the external capture source
`timescale 1ns/1ns
`default_nettype none
module rtp_far_side (
    input  wire logic       sys_clk_in,
    input  wire logic [3:0] modulated_out,
    input  wire logic [3:0] modulated_oe_out,
    output var  logic       stop_pin_n_out,
    output var  logic       capture_pin_out
);
    logic [3:0] line_level;
    initial begin
        stop_pin_n_out  = 1'b1;
        capture_pin_out = 1'b1;
        line_level      = 4'h0;
    end
    // a released line flips each cycle so a stale level never passes
    always @(posedge sys_clk_in) begin
        line_level <= (modulated_oe_out & modulated_out)
            | (~modulated_oe_out & ~line_level);
    end
    // pin moves off the clock edge, as an unrelated source would
    task automatic press_stop;
        #2 stop_pin_n_out = 1'b0;
    endtask
    task automatic release_stop;
        #2 stop_pin_n_out = 1'b1;
    endtask
    task automatic toggle_capture;
        #2 capture_pin_out = ~capture_pin_out;
    endtask
endmodule // rtp_far_side
`default_nettype wire

//--- sim/rtp_timer_top_bench.sv
// self-checking bench for the reload timer top
`timescale 1ns/1ns
`default_nettype none
module rtp_timer_top_bench;
    logic                   sys_clk_in;
    logic                   rst_n_in;
    logic                   lite_tick_in, fast_tick_in;
    rtp_pkg::rtp_clk_sel_e  count_clock_sel_in;
    rtp_pkg::rtp_sw_wr_s    sw_wr_in;
    rtp_pkg::rtp_stop_ctl_s stop_ctl_in;
    logic [3:0]             polarity_in, status_rd_in, port_value_in;
    logic                   polarity_sync_sel_in, compare_irq_en_in;
    logic                   capture_irq_en_in, wrap_irq_en_in;
    logic                   capture_rd_in, wrap_rd_in;
    wire logic              emergency_stop_pin_n_in, capture_input_pin_in;
    logic [3:0]             modulated_out, modulated_oe_out;
    logic [3:0]             output_enable_out, compare_flag_out;
    logic [11:0]            count_value_out, reload_value_out;
    logic [11:0]            capture_value_out;
    logic                   capture_flag_out, wrap_flag_out;
    logic                   stop_active_out, wrap_irq_out;
    logic                   compare_irq_out, capture_irq_out;
    int                     num_errors, n_compared, cycles;
    rtp_timer_top dut (.*);
    rtp_far_side far (
        .sys_clk_in, .modulated_out, .modulated_oe_out,
        .stop_pin_n_out(emergency_stop_pin_n_in),
        .capture_pin_out(capture_input_pin_in)
    );
    // ****
    // helpers
    // ****
    always #4 sys_clk_in = ~sys_clk_in;
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    // strobes in struct order: reload, duty 3..0, enable bits
    task automatic wr(logic [5:0] str, logic [11:0] val);
        sw_wr_in = {val, str};
        tick(1);
        sw_wr_in = '0;
        tick(1);
    endtask
    // ****
    // scenarios
    // ****
    task automatic test_reset;
        chk("count", 12'h000, count_value_out);
        count_clock_sel_in = rtp_pkg::RTP_CLK_CPU;
        tick(8);
        chk("count run", 12'h008, count_value_out);
        chk("flags zero duty", 12'h000, compare_flag_out);
        $display("test reset done");
    endtask
    task automatic test_pwm;
        logic [11:0] hi [4];
        polarity_in = 4'h4;
        port_value_in = 4'h8;
        wr(6'h20, 12'hFFC);
        wr(6'h02, 12'hFFE);
        wr(6'h08, 12'hFFD);
        wr(6'h10, 12'hFFF);
        wr(6'h01, 12'h007);
        chk("reload", 12'hFFC, reload_value_out);
        chk("enables", 12'h007, output_enable_out);
        tick(4300);
        hi = '{4{12'h000}};
        for (int k = 0; k < 16; k++) begin
            for (int c = 0; c < 4; c++) begin
                hi[c] = hi[c] + {11'h000, modulated_out[c]};
            end
            tick(1);
        end
        chk("ch0 high", 12'h008, hi[0]);
        chk("ch1 high", 12'h000, hi[1]);
        chk("ch2 high", 12'h00C, hi[2]);
        chk("ch3 high", 12'h010, hi[3]);
        chk("pin enables", 12'h007, modulated_oe_out);
        chk("cmp flags", 12'h00D, compare_flag_out);
        chk("cmp irq", 12'h001, compare_irq_out);
        chk("wrap flag", 12'h001, wrap_flag_out);
        count_clock_sel_in = rtp_pkg::RTP_CLK_OFF;
        tick(3);
        status_rd_in = 4'h1;
        tick(1);
        status_rd_in = 4'h0;
        tick(1);
        chk("flag read", 12'h00C, compare_flag_out);
        $display("test pwm done");
    endtask
    task automatic test_stop;
        stop_ctl_in.pattern = 4'hA;
        stop_ctl_in.set_stop = 1'b1;
        tick(1);
        stop_ctl_in.set_stop = 1'b0;
        chk("soft stop", 12'h001, stop_active_out);
        chk("pattern", 12'h00A, modulated_out);
        chk("stop drive", 12'h00F, modulated_oe_out);
        chk("stop count", 12'h000, count_value_out);
        chk("stop reload", 12'h000, reload_value_out);
        chk("stop enables", 12'h000, output_enable_out);
        stop_ctl_in.clear_stop = 1'b1;
        tick(1);
        stop_ctl_in.clear_stop = 1'b0;
        chk("cleared", 12'h000, stop_active_out);
        chk("port pins", 12'h008, modulated_out);
        chk("port drive", 12'h000, modulated_oe_out);
        far.press_stop();
        tick(6);
        chk("pin disabled", 12'h000, stop_active_out);
        stop_ctl_in.pin_enable = 1'b1;
        tick(4);
        chk("pin stop", 12'h001, stop_active_out);
        far.release_stop();
        stop_ctl_in.pin_enable = 1'b0;
        tick(4);
        stop_ctl_in.clear_stop = 1'b1;
        tick(1);
        stop_ctl_in.clear_stop = 1'b0;
        chk("pin cleared", 12'h000, stop_active_out);
        $display("test stop done");
    endtask
    task automatic test_capture;
        count_clock_sel_in = rtp_pkg::RTP_CLK_LITE;
        lite_tick_in = 1'b1;
        tick(5);
        lite_tick_in = 1'b0;
        chk("lite count", 12'h005, count_value_out);
        far.toggle_capture();
        tick(6);
        chk("cap value", 12'h005, capture_value_out);
        chk("cap flag", 12'h001, capture_flag_out);
        chk("cap irq", 12'h001, capture_irq_out);
        count_clock_sel_in = rtp_pkg::RTP_CLK_FAST;
        fast_tick_in = 1'b1;
        tick(2);
        fast_tick_in = 1'b0;
        chk("fast count", 12'h007, count_value_out);
        far.toggle_capture();
        tick(6);
        chk("cap kept", 12'h005, capture_value_out);
        capture_rd_in = 1'b1;
        tick(1);
        capture_rd_in = 1'b0;
        tick(1);
        chk("cap read", 12'h000, capture_flag_out);
        far.toggle_capture();
        tick(6);
        chk("cap again", 12'h007, capture_value_out);
        $display("test capture done");
    endtask
    initial begin
        sys_clk_in = 1'b0;
        rst_n_in = 1'b0;
        {lite_tick_in, fast_tick_in, capture_rd_in, wrap_rd_in} = '0;
        {wrap_irq_en_in, polarity_in, status_rd_in, port_value_in} = '0;
        {polarity_sync_sel_in, compare_irq_en_in, capture_irq_en_in} = '1;
        count_clock_sel_in = rtp_pkg::RTP_CLK_OFF;
        sw_wr_in = '0;
        stop_ctl_in = '0;
        num_errors = 0;
        n_compared = 0;
        cycles = 0;
        tick(4);
        rst_n_in = 1'b1;
        tick(1);
        test_reset();
        test_pwm();
        test_stop();
        test_capture();
        finish_test();
    end
endmodule // rtp_timer_top_bench
`default_nettype wire
